//--- verilog/fhb_defines.vh
// fhb_defines.vh - constants for the flash host bus pin control block
// How it works
// - decode 21, 22 or 23 address bits by density
// - data pins carry writes in, reads out
// - data pins high-z when chip or outputs deselected
// - write data latched internally during write cycle
// - sync read latches address on strobe rise or clock
// - latching clock edge rising or falling, selectable
// - sync burst steps internal address counter per edge
// - chip select asserted activates the device logic
// - chip select released gives standby, all outputs tri-state
// - data drivers enabled only while output enable asserted
// - output enable released keeps data pins high-z
// - reset pin low resets state, blocks writes
// - reset release resumes in asynchronous read-array mode
// - wait output tells host whether sync data valid
// - wait polarity chosen by read configuration bit 10
// - wait tri-stated while chip select released
// - wait driven regardless of output enable
// - write address and data taken on strobe rising edge
// - write-protect asserted enables lock-down, blocks software unlock
`ifndef FHB_DEFINES_VH
`define FHB_DEFINES_VH

// pin widths
`define FHB_ADDR_PINS 23
`define FHB_DATA_W    16
`define FHB_RCR_W     16

// address width per density in Mbit
`define FHB_AW_32M    21
`define FHB_AW_64M    22
`define FHB_AW_128M   23

// control pin vector positions
`define FHB_P_CE      0
`define FHB_P_OE      1
`define FHB_P_WE      2
`define FHB_P_ADV     3
`define FHB_P_BCLK    4
`define FHB_P_RST     5
`define FHB_P_WP      6
`define FHB_NPINS     7
// idle levels at reset: strobes high, bus clock low, reset pin held low
`define FHB_PIN_IDLE  7'h4F

// read configuration fields
`define FHB_RCR_WAITPOL 10
`define FHB_RCR_SYNC    15
`define FHB_RCR_EDGE    6
// asynchronous mode, wait active low, rising edge
`define FHB_RCR_RST     16'h8000

// read sequencer states
`define FHB_ST_IDLE   2'h0
`define FHB_ST_FETCH  2'h1
`define FHB_ST_HOLD   2'h2

`endif

//--- verilog/fhb_pin_ctrl.v
// fhb_pin_ctrl.v - host bus pin control of a 16-bit parallel flash
`timescale 1ns/1ns
`include "fhb_defines.vh"

module fhb_pin_ctrl #(
    parameter DENSITY_MBIT = 128
) (
    input  wire        clk_i,
    input  wire        resetn_i,
    input  wire        en_i,
    // host pins, all control pins but the bus clock active low
    input  wire [22:0] addr_i,
    input  wire [15:0] dq_i,
    output wire [15:0] dq_o,
    output wire        dq_oe_n_o,
    input  wire        ce_n_i,
    input  wire        oe_n_i,
    input  wire        we_n_i,
    input  wire        addr_valid_n_i,
    input  wire        bus_clk_i,
    input  wire        rst_n_i,
    input  wire        wp_n_i,
    output wire        wait_o,
    output wire        wait_oe_n_o,
    // read configuration from the command interface
    input  wire        rcr_load_i,
    input  wire [15:0] rcr_data_i,
    output wire        sync_mode_o,
    // write side toward the command interface
    output wire        cmd_wr_o,
    output wire [22:0] cmd_addr_o,
    output wire [15:0] cmd_data_o,
    // array read side
    output wire        arr_req_o,
    output wire [22:0] arr_addr_o,
    input  wire        arr_ack_i,
    input  wire [15:0] arr_data_i,
    // status
    output wire        standby_o,
    output wire        lockdown_en_o,
    output wire        dev_reset_o
);

////////////////////////////////////////////////////////////////////////////////
// address width and mask from density
// unknown densities fall back to the full 23-bit bus

localparam AW = (DENSITY_MBIT == 32) ? `FHB_AW_32M :
                (DENSITY_MBIT == 64) ? `FHB_AW_64M : `FHB_AW_128M;
localparam [22:0] AMASK = {23{1'b1}} >> (`FHB_ADDR_PINS - AW);

////////////////////////////////////////////////////////////////////////////////
// read sequencer state codes, binary

localparam [1:0] ST_IDLE  = `FHB_ST_IDLE;
localparam [1:0] ST_FETCH = `FHB_ST_FETCH;
localparam [1:0] ST_HOLD  = `FHB_ST_HOLD;

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers

reg  [6:0]  s1_q;
reg  [6:0]  s2_q;
reg  [6:0]  s3_q;
reg  [6:0]  filt_q;
wire [6:0]  pins;
wire [6:0]  agree;
wire [6:0]  filt_d;

reg  [22:0] a1_q;
reg  [22:0] a2_q;
reg  [22:0] a3_q;
reg  [15:0] d1_q;
reg  [15:0] d2_q;
reg  [15:0] d3_q;

assign pins  = {wp_n_i, rst_n_i, bus_clk_i, addr_valid_n_i, we_n_i, oe_n_i, ce_n_i};
assign agree = ~(s2_q ^ s3_q);
// a pin level counts only once the second and third stages agree
assign filt_d = (agree & s2_q) | (~agree & filt_q);

// only the second stage reads the first, which may still be settling
// three stages on controls; buses follow the same depth to stay aligned
always @(posedge clk_i) begin
    if (!resetn_i) begin
        s1_q   <= `FHB_PIN_IDLE;
        s2_q   <= `FHB_PIN_IDLE;
        s3_q   <= `FHB_PIN_IDLE;
        filt_q <= `FHB_PIN_IDLE;
        a1_q   <= 23'h000000;
        a2_q   <= 23'h000000;
        a3_q   <= 23'h000000;
        d1_q   <= 16'h0000;
        d2_q   <= 16'h0000;
        d3_q   <= 16'h0000;
    end else if (en_i) begin
        s1_q   <= pins;
        s2_q   <= s1_q;
        s3_q   <= s2_q;
        filt_q <= filt_d;
        a1_q   <= addr_i & AMASK;
        a2_q   <= a1_q;
        a3_q   <= a2_q;
        d1_q   <= dq_i;
        d2_q   <= d1_q;
        d3_q   <= d2_q;
    end
end

////////////////////////////////////////////////////////////////////////////////
// decoded controls and edges

reg         we_p_q;
reg         adv_p_q;
reg         bclk_p_q;
reg  [15:0] rcr_q;

// all strobes are asserted low
wire ce_act  = ~filt_q[`FHB_P_CE];
wire oe_act  = ~filt_q[`FHB_P_OE];
wire we_f    = filt_q[`FHB_P_WE];
wire adv_f   = filt_q[`FHB_P_ADV];
wire bclk_f  = filt_q[`FHB_P_BCLK];
wire rst_ok  = filt_q[`FHB_P_RST];
wire sync_md = ~rcr_q[`FHB_RCR_SYNC];
wire we_rise  = we_f & ~we_p_q;
wire adv_rise = adv_f & ~adv_p_q;
wire adv_fall = ~adv_f & adv_p_q;
// latching edge is selectable
wire bc_edge  = rcr_q[`FHB_RCR_EDGE] ? (~bclk_f & bclk_p_q)
                                     : (bclk_f & ~bclk_p_q);

// edge history; reset values equal the idle pin levels, so no
// false edge is seen in the first clocks after reset
always @(posedge clk_i) begin
    if (!resetn_i) begin
        we_p_q   <= 1'b1;
        adv_p_q  <= 1'b1;
        bclk_p_q <= 1'b0;
    end else if (en_i) begin
        we_p_q   <= we_f;
        adv_p_q  <= adv_f;
        bclk_p_q <= bclk_f;
    end
end

// read configuration; reset pin restores asynchronous read-array mode
// a load while the reset pin is low is lost, the pin takes priority
always @(posedge clk_i) begin
    if (!resetn_i) begin
        rcr_q <= `FHB_RCR_RST;
    end else if (en_i) begin
        if (!rst_ok) begin
            rcr_q <= `FHB_RCR_RST;
        end else if (rcr_load_i) begin
            rcr_q <= rcr_data_i;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// write capture

reg         wr_q;
reg  [22:0] wa_q;
reg  [15:0] wd_q;
reg  [22:0] cmd_a_q;
reg  [15:0] cmd_d_q;
// the filtered strobe lags the third bus stage by a clock, so the third
// strobe stage, aligned with a3_q and d3_q, gates capture: the word kept
// is the last one sampled while the strobe was low
wire        wr_low_al = !we_f && !s3_q[`FHB_P_WE];

// data follows the bus while the strobe is low, so the host
// need not hold it past the rising edge
always @(posedge clk_i) begin
    if (!resetn_i) begin
        wr_q    <= 1'b0;
        wa_q    <= 23'h000000;
        wd_q    <= 16'h0000;
        cmd_a_q <= 23'h000000;
        cmd_d_q <= 16'h0000;
    end else if (en_i) begin
        // cmd_wr_o is a one-clock pulse
        wr_q <= 1'b0;
        if (ce_act && wr_low_al) begin
            wa_q <= a3_q;
            wd_q <= d3_q;
        end
        // writes are refused while the reset pin is low
        if (ce_act && rst_ok && we_rise) begin
            wr_q    <= 1'b1;
            cmd_a_q <= wa_q;
            cmd_d_q <= wd_q;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// read sequencer

reg  [1:0]  st_q;
reg  [1:0]  st_d;
reg         lat_q;
reg         req_q;
reg  [22:0] ra_q;
reg         vld_q;
reg  [15:0] rd_q;

// sync reads need no output enable; it gates only the drivers
// a strobe fall opens a new address phase
wire lat_eff  = lat_q & ~adv_fall;
wire sync_lat = sync_md && !lat_eff && (adv_rise || (!adv_f && bc_edge));
// burst edges during a fetch are ignored; the host must honour wait
wire sync_inc = sync_md && lat_eff && bc_edge && (st_q == ST_HOLD);
wire asyn_go  = !sync_md && oe_act && (st_q != ST_FETCH)
                && (!vld_q || (a3_q != ra_q));
// a deselected device, or one held in pin reset, starts nothing
wire live     = ce_act && rst_ok;

// next state
always @* begin
    st_d = st_q;
    case (st_q)
        ST_IDLE: begin
            // wait for a sync latch or a new async address
            if (live && (sync_lat || asyn_go)) begin
                st_d = ST_FETCH;
            end
        end
        ST_FETCH: begin
            // one request outstanding until the array answers
            if (!live) begin
                st_d = ST_IDLE;
            end else if (arr_ack_i) begin
                st_d = ST_HOLD;
            end
        end
        ST_HOLD: begin
            // data stands on the bus until the next fetch
            if (!live) begin
                st_d = ST_IDLE;
            end else if (sync_lat || sync_inc || asyn_go) begin
                st_d = ST_FETCH;
            end
        end
        default: begin
            st_d = ST_IDLE;
        end
    endcase
end

// address, data and request registers
always @(posedge clk_i) begin
    if (!resetn_i) begin
        st_q  <= ST_IDLE;
        lat_q <= 1'b0;
        req_q <= 1'b0;
        ra_q  <= 23'h000000;
        vld_q <= 1'b0;
        rd_q  <= 16'h0000;
    end else if (en_i) begin
        st_q  <= st_d;
        req_q <= 1'b0;
        if (!live) begin
            // standby or reset pin: drop any burst in flight
            lat_q <= 1'b0;
            vld_q <= 1'b0;
        end else begin
            lat_q <= lat_eff;
            // first cycle of a fetch picks the address source
            if (st_d == ST_FETCH && st_q != ST_FETCH) begin
                req_q <= 1'b1;
                vld_q <= 1'b0;
                if (sync_lat) begin
                    ra_q  <= a3_q;
                    lat_q <= 1'b1;
                end else if (sync_inc) begin
                    // burst counter wraps within the decoded range
                    ra_q <= (ra_q + 23'h000001) & AMASK;
                end else begin
                    ra_q <= a3_q;
                end
            end
            // the array answer is honoured only while fetching
            if (st_q == ST_FETCH && arr_ack_i) begin
                rd_q  <= arr_data_i;
                vld_q <= 1'b1;
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// pin drivers

reg        dq_oe_n_q;
reg        wait_q;
reg        wait_oe_n_q;
reg        stby_q;
reg        lock_q;

// limitation: the pin filter delays every strobe by four clocks, so
// the bus clock must run well below clk_i
// wait is asserted while sync data is not yet valid
wire wait_act = sync_md && lat_q && !vld_q;

// drivers registered so every pin leaves a flip-flop
always @(posedge clk_i) begin
    if (!resetn_i) begin
        dq_oe_n_q   <= 1'b1;
        wait_q      <= 1'b0;
        wait_oe_n_q <= 1'b1;
        stby_q      <= 1'b1;
        lock_q      <= 1'b0;
    end else if (en_i) begin
        // drive only when selected, outputs enabled and not writing
        dq_oe_n_q   <= ~(ce_act && oe_act && we_f);
        // polarity bit set means asserted high
        wait_q      <= rcr_q[`FHB_RCR_WAITPOL] ? wait_act : ~wait_act;
        // wait ignores output enable, follows chip select only
        wait_oe_n_q <= ~ce_act;
        stby_q      <= ~ce_act;
        // lock-down only follows the pin; block locking lives elsewhere
        lock_q      <= ~filt_q[`FHB_P_WP];
    end
end

// pins and status straight from their registers
assign dq_o          = rd_q;
assign dq_oe_n_o     = dq_oe_n_q;
assign wait_o        = wait_q;
assign wait_oe_n_o   = wait_oe_n_q;
assign sync_mode_o   = sync_md;
assign cmd_wr_o      = wr_q;
assign cmd_addr_o    = cmd_a_q;
assign cmd_data_o    = cmd_d_q;
assign arr_req_o     = req_q;
assign arr_addr_o    = ra_q;
assign standby_o     = stby_q;
assign lockdown_en_o = lock_q;
assign dev_reset_o   = ~rst_ok;

endmodule // fhb_pin_ctrl

//--- tb/fhb_arr_mdl.sv
// array model that answers read requests of the pin control block
`timescale 1ns/1ns
module fhb_arr_mdl (
    input  wire        clk_i,
    input  wire        arr_req_i,
    input  wire [22:0] arr_addr_i,
    output reg         arr_ack_o = 1'h0,
    output reg  [15:0] arr_data_o = 16'h0000
);
    int          cnt_q = -1;
    logic [22:0] addr_q;
    // latency follows the low address bits, so prompt and slow answers both occur;
    // data lines churn between answers so a stale word never passes for a fresh one
    always @(posedge clk_i) begin
        arr_ack_o  <= (cnt_q == 0);
        arr_data_o <= (cnt_q == 0) ? addr_q[15:0] ^ 16'h5A5A : ~arr_data_o;
        if (arr_req_i) begin
            cnt_q  <= 1 + arr_addr_i[1:0];
            addr_q <= arr_addr_i;
        end else if (cnt_q >= 0) begin
            cnt_q <= cnt_q - 1;
        end
    end
endmodule // fhb_arr_mdl

//--- tb/fhb_pin_chk.sv
// concurrent checks on the pins of the flash host bus pin control block
`timescale 1ns/1ns
module fhb_pin_chk #(
    parameter DENSITY_MBIT = 128
) (
    input wire clk_i,
    input wire resetn_i,
    input wire ce_n_i,
    input wire oe_n_i,
    input wire we_n_i,
    input wire rst_n_i,
    input wire dq_oe_n_o,
    input wire wait_oe_n_o,
    input wire sync_mode_o,
    input wire cmd_wr_o,
    input wire arr_req_o,
    input wire standby_o,
    input wire dev_reset_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    ////////////////////////////////////////
    // pin filters take up to five edges, so a level is held six before judging
    desel_float_a: assert property (ce_n_i [*6] |->
        standby_o && dq_oe_n_o && wait_oe_n_o) else $error("outputs driven while deselected");
    oe_float_a: assert property (oe_n_i [*6] |-> dq_oe_n_o)
        else $error("data driven with outputs disabled");
    wait_drive_a: assert property ((!ce_n_i && oe_n_i && rst_n_i) [*6] |-> !wait_oe_n_o)
        else $error("wait floated while selected");
    wr_take_a: assert property ((!we_n_i && !ce_n_i && rst_n_i) [*4] ##1
        (we_n_i && !ce_n_i && rst_n_i) |-> ##[2:8] cmd_wr_o) else $error("write not taken");
    wr_pulse_a: assert property (cmd_wr_o |=> !cmd_wr_o)
        else $error("write pulse too long");
    wr_sel_a: assert property (cmd_wr_o |-> !standby_o)
        else $error("write taken in standby");
    rst_block_a: assert property (!rst_n_i [*8] |-> dev_reset_o && !cmd_wr_o)
        else $error("write passed during pin reset");
    rst_async_a: assert property ($fell(dev_reset_o) |-> !sync_mode_o)
        else $error("left pin reset in burst mode");
    cover property (cmd_wr_o);
    cover property (arr_req_o && sync_mode_o);
    cover property ($fell(dev_reset_o));
endmodule // fhb_pin_chk
////////////////////////////////////////
bind fhb_pin_ctrl fhb_pin_chk #(.DENSITY_MBIT(DENSITY_MBIT)) fhb_pin_chk_i (
    .clk_i, .resetn_i, .ce_n_i, .oe_n_i, .we_n_i, .rst_n_i, .dq_oe_n_o, .wait_oe_n_o,
    .sync_mode_o, .cmd_wr_o, .arr_req_o, .standby_o, .dev_reset_o
);

//--- tb/tb.sv
// self-checking bench for the flash host bus pin control block
`timescale 1ns/1ns
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_fail++; \
    $display("unexpected at %0t: value differs", $time); end end
module tb;
    logic        clk_i = 1'h0, resetn_i = 1'h0, ce_n_i = 1'h1, oe_n_i = 1'h1, we_n_i = 1'h1;
    logic        addr_valid_n_i = 1'h1, bus_clk_i = 1'h0, rst_n_i = 1'h1, wp_n_i = 1'h1;
    logic        rcr_load_i = 1'h0;
    logic [22:0] addr_i = 23'h0;
    logic [15:0] dq_i = 16'h0, rcr_data_i = 16'h0;
    wire  [22:0] cmd_addr_o, arr_addr_o;
    wire  [15:0] dq_o, cmd_data_o, arr_data_i;
    wire         dq_oe_n_o, wait_o, wait_oe_n_o, sync_mode_o, cmd_wr_o, arr_req_o, arr_ack_i;
    wire         standby_o, lockdown_en_o, dev_reset_o;
    int          n_fail = 0, cmp_count = 0, hits, k;
    // 25 MHz system clock
    always #20 clk_i = ~clk_i;
    // full density decodes all 23 address pins; the clock enable stays high, freeze untested
    fhb_pin_ctrl #(.DENSITY_MBIT(128)) fhb_pin_ctrl_i (
        .clk_i, .resetn_i, .en_i(1'h1), .addr_i, .dq_i, .dq_o, .dq_oe_n_o, .ce_n_i, .oe_n_i,
        .we_n_i, .addr_valid_n_i, .bus_clk_i, .rst_n_i, .wp_n_i, .wait_o, .wait_oe_n_o,
        .rcr_load_i, .rcr_data_i, .sync_mode_o, .cmd_wr_o, .cmd_addr_o, .cmd_data_o,
        .arr_req_o, .arr_addr_o, .arr_ack_i, .arr_data_i, .standby_o, .lockdown_en_o,
        .dev_reset_o
    );
    fhb_arr_mdl fhb_arr_mdl_i (.clk_i, .arr_req_i(arr_req_o), .arr_addr_i(arr_addr_o),
        .arr_ack_o(arr_ack_i), .arr_data_o(arr_data_i));
    ////////////////////////////////////////
    // helpers
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    function automatic logic [15:0] exp_word(input logic [22:0] a);
        return a[15:0] ^ 16'h5A5A;
    endfunction
    task automatic wt_dq(input logic [15:0] e);
        for (k = 0; k < 80 && dq_o !== e; k++) cyc(1);
    endtask
    // data flips at the strobe rise so a late capture would be seen
    task automatic wr(input logic ce, input logic [22:0] a, input logic [15:0] d);
        ce_n_i <= ce;
        addr_i <= a;
        dq_i   <= d;
        we_n_i <= 1'h0;
        cyc(5);
        we_n_i <= 1'h1;
        dq_i   <= ~d;
        hits = 0;
        repeat (12) begin
            cyc(1);
            hits += (cmd_wr_o === 1'h1);
        end
        ce_n_i <= 1'h1;
        cyc(1);
    endtask
    ////////////////////////////////////////
    // scenarios
    task automatic t_write;
        wr(1'h0, 23'h4ABCDE, 16'hC3A5);
        `CHK(hits, 1);
        `CHK(cmd_addr_o, 23'h4ABCDE);
        `CHK(cmd_data_o, 16'hC3A5);
        wr(1'h1, 23'h000123, 16'h1111);
        `CHK(hits, 0);
        $display("write done");
    endtask
    task automatic t_async;
        addr_i <= 23'h2001F5;
        ce_n_i <= 1'h0;
        oe_n_i <= 1'h0;
        wt_dq(exp_word(23'h2001F5));
        `CHK(dq_o, exp_word(23'h2001F5));
        `CHK(dq_oe_n_o, 1'h0);
        oe_n_i <= 1'h1;
        cyc(7);
        `CHK(dq_oe_n_o, 1'h1);
        `CHK(standby_o, 1'h0);
        ce_n_i <= 1'h1;
        cyc(7);
        `CHK(standby_o, 1'h1);
        `CHK(wait_oe_n_o, 1'h1);
        $display("async read done");
    endtask
    // pass 0: wait active high, rising edge, top address wraps; pass 1: low, falling
    task automatic t_sync;
        logic [22:0] a;
        for (int p = 0; p < 2; p++) begin
            a = p ? 23'h012345 : 23'h7FFFFF;
            rcr_data_i     <= p ? 16'h0040 : 16'h0400;
            rcr_load_i     <= 1'h1;
            cyc(1);
            rcr_load_i     <= 1'h0;
            addr_i         <= a;
            ce_n_i         <= 1'h0;
            addr_valid_n_i <= 1'h0;
            cyc(6);
            if (p) addr_valid_n_i <= 1'h1;
            else bus_clk_i <= 1'h1;
            cyc(5);
            bus_clk_i <= 1'h0;
            cyc(2);
            `CHK(wait_o, ~p[0]);
            `CHK(sync_mode_o, 1'h1);
            wt_dq(exp_word(a));
            `CHK(dq_o, exp_word(a));
            cyc(4);
            `CHK(wait_o, p[0]);
            `CHK(wait_oe_n_o, 1'h0);
            bus_clk_i <= 1'h1;
            cyc(5);
            bus_clk_i <= 1'h0;
            a = a + 23'h1;
            wt_dq(exp_word(a));
            `CHK(dq_o, exp_word(a));
            ce_n_i         <= 1'h1;
            addr_valid_n_i <= 1'h1;
            cyc(7);
        end
        $display("sync read done");
    endtask
    task automatic t_rstpin;
        rst_n_i <= 1'h0;
        wp_n_i  <= 1'h0;
        cyc(8);
        `CHK(dev_reset_o, 1'h1);
        `CHK(lockdown_en_o, 1'h1);
        wr(1'h0, 23'h000055, 16'h0F0F);
        `CHK(hits, 0);
        rst_n_i <= 1'h1;
        wp_n_i  <= 1'h1;
        cyc(8);
        `CHK(sync_mode_o, 1'h0);
        `CHK(lockdown_en_o, 1'h0);
        $display("reset pin done");
    endtask
    task final_report;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////
    // main sequence
    initial begin
        cyc(10);
        resetn_i <= 1'h1;
        cyc(2);
        t_write;
        t_async;
        t_sync;
        t_rstpin;
        final_report;
    end
    // the run needs well under a thousand cycles
    initial begin
        #(40 * 5000);
        n_fail++;
        $display("unexpected at %0t: watchdog expired", $time);
        final_report;
    end
endmodule // tb
